// *** cwd_cfg.svh ***
`ifndef CWD_CFG_SVH
`define CWD_CFG_SVH

// Configuration word location and layout.
`define CWD_WORD_ADDR        14'h2007
`define CWD_WORD_W           14
`define CWD_ERASED_WORD      14'h3fff
`define CWD_IMPL_MASK        14'h31ff
`define CWD_BG_HI            13
`define CWD_BG_LO            12
`define CWD_DATA_PROT_BIT    8
`define CWD_PROG_PROT_BIT    7
`define CWD_BROWNOUT_BIT     6
`define CWD_RESET_PIN_BIT    5
`define CWD_POWERUP_N_BIT    4
`define CWD_WATCHDOG_BIT     3
`define CWD_OSC_HI           2
`define CWD_OSC_LO           0

// Timing at a 25 MHz reference clock.
`define CWD_CLK_HZ           25000000
`define CWD_POWERUP_MS       72
`define CWD_BROWNOUT_MS      72
`define CWD_POWERUP_CYC      ((`CWD_CLK_HZ / 1000) * `CWD_POWERUP_MS)
`define CWD_BROWNOUT_CYC     ((`CWD_CLK_HZ / 1000) * `CWD_BROWNOUT_MS)
`define CWD_SETTLE_CYC       1024
`define CWD_WDOG_DIV         16
`define CWD_CNT_W            24

`endif

// *** cwd_pkg.sv ***
package cwd_pkg;

	typedef enum logic [2:0]
	{
		CWD_OSC_LOW_POWER_XTAL  = 3'h0,
		CWD_OSC_STD_XTAL        = 3'h1,
		CWD_OSC_HIGH_SPEED_XTAL = 3'h2,
		CWD_OSC_EXT_CLOCK       = 3'h3,
		CWD_OSC_INT_IO          = 3'h4,
		CWD_OSC_INT_CLOCK_OUTPUT_PIN      = 3'h5,
		CWD_OSC_RC_IO           = 3'h6,
		CWD_OSC_RC_CLOCK_OUTPUT_PIN       = 3'h7
	} cwd_osc_e;

	typedef enum logic [2:0]
	{
		CWD_ST_LOAD,
		CWD_ST_ERASE,
		CWD_ST_POWERUP,
		CWD_ST_SETTLE,
		CWD_ST_RUN,
		CWD_ST_BROWNOUT
	} cwd_state_e;

endpackage

// *** cwd_word_store.sv ***
`timescale 1ns/1ps
`include "cwd_cfg.svh"

// Nonvolatile configuration word cell; read data come from a register.
module cwd_word_store
#(
	parameter int WIDTH = `CWD_WORD_W
)
(
	input  wire logic             ref_clk_i,
	input  wire logic             reset_i,
	input  wire logic             write_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	output logic      [WIDTH-1:0] rdata_o
);
	logic [WIDTH-1:0] cell_reg;
	logic [WIDTH-1:0] cell_next;
	logic [WIDTH-1:0] rdata_reg;

	// Erased state reads ones in every implemented bit, so a blank part comes up with brown-out, watchdog and reset pin on.
	always_comb
	begin
		cell_next = cell_reg;
		if (write_i)
		begin
			cell_next = wdata_i & WIDTH'(`CWD_IMPL_MASK);
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			cell_reg  <= WIDTH'(`CWD_ERASED_WORD) & WIDTH'(`CWD_IMPL_MASK);
			rdata_reg <= '0;
		end
		else
		begin
			cell_reg  <= cell_next;
			rdata_reg <= cell_reg;
		end
	end

	assign rdata_o = rdata_reg;

endmodule

// *** cwd_option_decoder.sv ***
`timescale 1ns/1ps
`include "cwd_cfg.svh"

// Summary of operation
// - Option bits read zero when programmed and one when erased.
// - Word lives at its config address, accessible only in programming mode.
// - Two top bits trim the bandgap reference, 00 lowest to 11 highest.
// - Bit 8 low enables data memory read-out protection.
// - Bit 7 low enables program memory read-out protection.
// - Dropping data protection erases all data nonvolatile memory.
// - Dropping program protection erases program memory and calibration value.
// - Bit 6 high turns the brown-out detector on.
// - Brown-out enable does not enable the power-up delay timer.
// - Bit 5 high makes the shared pin active-low reset, else I/O.
// - Bit 4 low enables the power-up delay timer.
// - Power-up delay holds reset 72 ms on every reload while power_on_i is high.
// - Brown-out holds reset for at least 72 ms.
// - Bit 3 high turns the watchdog timer on.
// - Watchdog runs from its own oscillator, not the system clock.
// - Settle timer holds reset until the crystal oscillator is stable.
// - Codes 111, 110 are RC modes; 101 internal with clock output.
// - Code 100 internal with pins I/O; 011 external clock input.
// - Codes 010, 001, 000 are high-speed, standard, low-power crystals.
// - Crystal modes also accept an external clock on pin one.
// - External reset stops internal clock in internal or RC modes.
// - Sleep ends on external reset, watchdog wake-up or enabled interrupt.
// - Clock-output modes drive oscillator frequency divided by four on pin two.
module cwd_option_decoder
#(
	parameter int POWERUP_CYC  = `CWD_POWERUP_CYC,
	parameter int BROWNOUT_CYC = `CWD_BROWNOUT_CYC,
	parameter int SETTLE_CYC   = `CWD_SETTLE_CYC,
	parameter int WDOG_DIV     = `CWD_WDOG_DIV
)
(
	input  wire logic                    ref_clk_i,
	input  wire logic                    reset_i,
	input  wire logic                    prog_mode_i,
	input  wire logic [13:0]             prog_addr_i,
	input  wire logic                    prog_write_i,
	input  wire logic [13:0]             prog_wdata_i,
	output logic      [13:0]             prog_rdata_o,
	input  wire logic                    power_on_i,
	input  wire logic                    brownout_i,
	input  wire logic                    shared_pin_three_i,
	input  wire logic                    wdog_osc_i,
	input  wire logic                    sleep_i,
	input  wire logic                    irq_wake_i,
	input  wire logic                    sys_osc_i,
	output logic      [1:0]              bandgap_trim_o,
	output logic                         data_protect_o,
	output logic                         prog_protect_o,
	output logic                         brownout_detect_enable_o,
	output logic                         reset_pin_select_o,
	output logic                         powerup_delay_enable_o,
	output logic                         watchdog_enable_o,
	output cwd_pkg::cwd_osc_e            oscillator_select_o,
	output logic                         crystal_mode_o,
	output logic                         ext_clock_accept_o,
	output logic                         pin_one_io_o,
	output logic                         pin_two_io_o,
	output logic                         clock_output_pin_o,
	output logic                         clock_output_oe_o,
	output logic                         int_osc_stop_o,
	output logic                         data_erase_o,
	output logic                         prog_erase_o,
	output logic                         core_reset_o,
	output logic                         wdog_tick_o,
	output logic                         wake_o
);
	import cwd_pkg::*;

	// ----------------------------------------------------------------
	// Word storage and programmer access
	// ----------------------------------------------------------------
	logic        hit;
	logic        store_write;
	logic [13:0] store_rdata;

	assign hit         = prog_mode_i && (prog_addr_i == `CWD_WORD_ADDR);
	assign store_write = hit && prog_write_i;

	cwd_word_store #(.WIDTH(`CWD_WORD_W)) u_store
	(
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.write_i   (store_write),
		.wdata_i   (prog_wdata_i),
		.rdata_o   (store_rdata)
	);

	// Running code never sees the word; only the programmer path reads it.
	assign prog_rdata_o = hit ? store_rdata : 14'h0000;

	// ----------------------------------------------------------------
	// Sequencer and latched options
	// ----------------------------------------------------------------
	cwd_state_e         state_reg;
	cwd_state_e         state_next;
	logic [13:0]        opt_reg;
	logic [13:0]        opt_next;
	logic [`CWD_CNT_W-1:0] cnt_reg;
	logic [`CWD_CNT_W-1:0] cnt_next;
	logic               derase_reg;
	logic               derase_next;
	logic               perase_reg;
	logic               perase_next;
	logic               load_wait_reg;
	logic               load_wait_next;
	logic               old_dprot;
	logic               old_pprot;
	logic               new_dprot;
	logic               new_pprot;
	logic               ext_reset;

	assign old_dprot = ~opt_reg[`CWD_DATA_PROT_BIT];
	assign old_pprot = ~opt_reg[`CWD_PROG_PROT_BIT];
	assign new_dprot = ~prog_wdata_i[`CWD_DATA_PROT_BIT];
	assign new_pprot = ~prog_wdata_i[`CWD_PROG_PROT_BIT];

	always_comb
	begin
		state_next     = state_reg;
		opt_next       = opt_reg;
		cnt_next       = cnt_reg;
		derase_next    = 1'b0;
		perase_next    = 1'b0;
		load_wait_next = 1'b0;
		// Protection turned off by the programmer wipes the guarded memory.
		if (store_write && old_dprot && !new_dprot)
		begin
			derase_next = 1'b1;
		end
		if (store_write && old_pprot && !new_pprot)
		begin
			perase_next = 1'b1;
		end
		unique case (state_reg)
			CWD_ST_LOAD:
			begin
				// The store needs one cycle to present its registered word.
				load_wait_next = 1'b1;
				if (load_wait_reg)
				begin
					opt_next = store_rdata;
					if (!store_rdata[`CWD_POWERUP_N_BIT] && power_on_i)
					begin
						state_next = CWD_ST_POWERUP;
						cnt_next   = `CWD_CNT_W'(POWERUP_CYC - 1);
					end
					else if (store_rdata[`CWD_OSC_HI:`CWD_OSC_LO] <= 3'h2)
					begin
						state_next = CWD_ST_SETTLE;
						cnt_next   = `CWD_CNT_W'(SETTLE_CYC - 1);
					end
					else
					begin
						state_next = CWD_ST_RUN;
					end
				end
			end
			CWD_ST_POWERUP:
			begin
				if (cnt_reg == '0)
				begin
					state_next = (opt_reg[`CWD_OSC_HI:`CWD_OSC_LO] <= 3'h2) ?
						CWD_ST_SETTLE : CWD_ST_RUN;
					cnt_next   = `CWD_CNT_W'(SETTLE_CYC - 1);
				end
				else
				begin
					cnt_next = cnt_reg - 1'b1;
				end
			end
			CWD_ST_SETTLE:
			begin
				if (cnt_reg == '0)
				begin
					state_next = CWD_ST_RUN;
				end
				else
				begin
					cnt_next = cnt_reg - 1'b1;
				end
			end
			CWD_ST_BROWNOUT:
			begin
				// Hold restarts while the supply stays low.
				if (brownout_i)
				begin
					cnt_next = `CWD_CNT_W'(BROWNOUT_CYC - 1);
				end
				else if (cnt_reg == '0)
				begin
					state_next = CWD_ST_LOAD;
				end
				else
				begin
					cnt_next = cnt_reg - 1'b1;
				end
			end
			CWD_ST_RUN:
			begin
				if (ext_reset)
				begin
					state_next = CWD_ST_LOAD;
				end
			end
			CWD_ST_ERASE:
			begin
				state_next = CWD_ST_LOAD;
			end
		endcase
		// Keep the protect view current so a later write sees the change.
		// Applied after the load so a write on the latching edge is not lost.
		if (store_write)
		begin
			opt_next[`CWD_DATA_PROT_BIT] = prog_wdata_i[`CWD_DATA_PROT_BIT];
			opt_next[`CWD_PROG_PROT_BIT] = prog_wdata_i[`CWD_PROG_PROT_BIT];
		end
		// Brown-out only acts when its enable was latched, independent of delay bit.
		if (opt_reg[`CWD_BROWNOUT_BIT] && brownout_i)
		begin
			state_next = CWD_ST_BROWNOUT;
			cnt_next   = `CWD_CNT_W'(BROWNOUT_CYC - 1);
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_reg     <= CWD_ST_LOAD;
			opt_reg       <= `CWD_ERASED_WORD;
			cnt_reg       <= '0;
			derase_reg    <= 1'b0;
			perase_reg    <= 1'b0;
			load_wait_reg <= 1'b0;
		end
		else
		begin
			state_reg     <= state_next;
			opt_reg       <= opt_next;
			cnt_reg       <= cnt_next;
			derase_reg    <= derase_next;
			perase_reg    <= perase_next;
			load_wait_reg <= load_wait_next;
		end
	end

	// ----------------------------------------------------------------
	// Option decode
	// ----------------------------------------------------------------
	cwd_osc_e osc;

	assign osc = cwd_osc_e'(opt_reg[`CWD_OSC_HI:`CWD_OSC_LO]);

	// With the pin as I/O the internal reset input is held inactive.
	assign ext_reset = opt_reg[`CWD_RESET_PIN_BIT] && !shared_pin_three_i;

	assign bandgap_trim_o           = opt_reg[`CWD_BG_HI:`CWD_BG_LO];
	assign data_protect_o           = ~opt_reg[`CWD_DATA_PROT_BIT];
	assign prog_protect_o           = ~opt_reg[`CWD_PROG_PROT_BIT];
	assign brownout_detect_enable_o = opt_reg[`CWD_BROWNOUT_BIT];
	assign reset_pin_select_o       = opt_reg[`CWD_RESET_PIN_BIT];
	assign powerup_delay_enable_o   = ~opt_reg[`CWD_POWERUP_N_BIT];
	assign watchdog_enable_o        = opt_reg[`CWD_WATCHDOG_BIT];
	assign oscillator_select_o      = osc;
	assign data_erase_o             = derase_reg;
	assign prog_erase_o             = perase_reg;
	assign core_reset_o             = (state_reg != CWD_ST_RUN) || ext_reset;
	assign wake_o                   = sleep_i && (ext_reset || wdog_tick_o || irq_wake_i);

	always_comb
	begin
		crystal_mode_o     = 1'b0;
		ext_clock_accept_o = 1'b0;
		pin_one_io_o       = 1'b0;
		pin_two_io_o       = 1'b0;
		clock_output_oe_o  = 1'b0;
		int_osc_stop_o     = 1'b0;
		unique case (osc)
			CWD_OSC_RC_CLOCK_OUTPUT_PIN:       clock_output_oe_o = 1'b1;
			CWD_OSC_RC_IO:           pin_two_io_o = 1'b1;
			CWD_OSC_INT_CLOCK_OUTPUT_PIN:
			begin
				clock_output_oe_o = 1'b1;
				pin_one_io_o      = 1'b1;
			end
			CWD_OSC_INT_IO:
			begin
				pin_one_io_o = 1'b1;
				pin_two_io_o = 1'b1;
			end
			CWD_OSC_EXT_CLOCK:
			begin
				ext_clock_accept_o = 1'b1;
				pin_two_io_o       = 1'b1;
			end
			CWD_OSC_HIGH_SPEED_XTAL,
			CWD_OSC_STD_XTAL,
			CWD_OSC_LOW_POWER_XTAL:
			begin
				crystal_mode_o     = 1'b1;
				ext_clock_accept_o = 1'b1;
			end
		endcase
		if (osc >= CWD_OSC_INT_IO)
		begin
			int_osc_stop_o = ext_reset;
		end
	end

	// ----------------------------------------------------------------
	// Clock output and watchdog tick
	// ----------------------------------------------------------------
	// The system oscillator is sampled as a level; divide its rising edges by four.
	logic       osc_d_reg;
	logic [1:0] div_reg;
	logic [1:0] div_next;
	logic       clko_reg;
	logic       clko_next;
	logic       wd_d_reg;
	logic [$clog2(WDOG_DIV)-1:0] wd_cnt_reg;
	logic [$clog2(WDOG_DIV)-1:0] wd_cnt_next;
	logic       wd_tick_reg;
	logic       wd_tick_next;

	always_comb
	begin
		div_next     = div_reg;
		clko_next    = clko_reg;
		wd_cnt_next  = wd_cnt_reg;
		wd_tick_next = 1'b0;
		if (sys_osc_i && !osc_d_reg)
		begin
			div_next = div_reg + 2'h1;
			if (div_reg[0])
			begin
				clko_next = ~clko_reg;
			end
		end
		// Watchdog time base counts only its own oscillator's edges.
		if (watchdog_enable_o && wdog_osc_i && !wd_d_reg)
		begin
			wd_cnt_next = wd_cnt_reg + 1'b1;
			if (wd_cnt_reg == ($clog2(WDOG_DIV))'(WDOG_DIV - 1))
			begin
				wd_tick_next = 1'b1;
				wd_cnt_next  = '0;
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			osc_d_reg   <= 1'b0;
			div_reg     <= 2'h0;
			clko_reg    <= 1'b0;
			wd_d_reg    <= 1'b0;
			wd_cnt_reg  <= '0;
			wd_tick_reg <= 1'b0;
		end
		else
		begin
			osc_d_reg   <= sys_osc_i;
			div_reg     <= div_next;
			clko_reg    <= clko_next;
			wd_d_reg    <= wdog_osc_i;
			wd_cnt_reg  <= wd_cnt_next;
			wd_tick_reg <= wd_tick_next;
		end
	end

	assign clock_output_pin_o = clock_output_oe_o & clko_reg;
	// A tick already in flight when the watchdog is switched off is dropped.
	assign wdog_tick_o        = wd_tick_reg & watchdog_enable_o;

endmodule

// *** cwd_partner.sv ***
`timescale 1ns/1ps
module cwd_partner
(
	input  wire logic        ref_clk_i,
	output logic             prog_mode_o,
	output logic      [13:0] prog_addr_o,
	output logic             prog_write_o,
	output logic      [13:0] prog_wdata_o,
	output logic             sys_osc_o,
	output logic             wdog_osc_o
);
	initial
	begin
		prog_mode_o = 1'b0;
		prog_addr_o = 14'h0000;
		prog_write_o = 1'b0;
		prog_wdata_o = 14'h0000;
		sys_osc_o = 1'b0;
		wdog_osc_o = 1'b0;
	end

	// The watchdog source is unrelated in rate and phase to the system clock.
	always #61 wdog_osc_o = !wdog_osc_o;
	always #50 sys_osc_o = !sys_osc_o;

	// The programmer writes with programming mode set from the mode argument; released data shows the inverse.
	// A mode of zero models a write tried outside programming mode, which must be refused.
	task automatic put(input logic [13:0] addr, input logic [13:0] data, input logic mode);
		@(posedge ref_clk_i);
		#2;
		prog_mode_o = mode;
		prog_addr_o = addr;
		prog_wdata_o = data;
		prog_write_o = 1'b1;
		@(posedge ref_clk_i);
		#2;
		prog_write_o = 1'b0;
		prog_wdata_o = ~data;
	endtask
endmodule

// *** cwd_chk.sv ***
`timescale 1ns/1ps
module cwd_chk
(
	input wire logic              ref_clk_i,
	input wire logic              reset_i,
	input wire logic              prog_mode_i,
	input wire logic [13:0]       prog_addr_i,
	input wire logic              prog_write_i,
	input wire logic [13:0]       prog_wdata_i,
	input wire logic [13:0]       prog_rdata_o,
	input wire logic              brownout_i,
	input wire logic              shared_pin_three_i,
	input wire logic              sleep_i,
	input wire logic              irq_wake_i,
	input wire logic [1:0]        bandgap_trim_o,
	input wire logic              brownout_detect_enable_o,
	input wire logic              reset_pin_select_o,
	input wire logic              watchdog_enable_o,
	input wire cwd_pkg::cwd_osc_e oscillator_select_o,
	input wire logic              crystal_mode_o,
	input wire logic              clock_output_pin_o,
	input wire logic              clock_output_oe_o,
	input wire logic              int_osc_stop_o,
	input wire logic              data_erase_o,
	input wire logic              core_reset_o,
	input wire logic              wdog_tick_o,
	input wire logic              wake_o
);
	import cwd_pkg::*;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	logic hit;
	logic ext_rst;
	assign hit = prog_mode_i && prog_write_i && prog_addr_i == 14'h2007;
	assign ext_rst = reset_pin_select_o && !shared_pin_three_i;
	sequence bo_drop;
		brownout_detect_enable_o && brownout_i ##1 !brownout_i;
	endsequence
	sequence long_hold;
		core_reset_o [*8] ##12 core_reset_o;
	endsequence
	rdata_refuse_a: assert property (!prog_mode_i |-> prog_rdata_o == 14'h0000)
		else $error("read data outside programming mode");
	erase_cause_a: assert property (data_erase_o |-> $past(hit && prog_wdata_i[8]))
		else $error("data erase without a clearing write");
	bo_hold_a: assert property (bo_drop |-> long_hold)
		else $error("brown-out hold too short");
	wake_cause_a: assert property (wake_o == (sleep_i && (ext_rst || wdog_tick_o || irq_wake_i)))
		else $error("wake mismatch");
	osc_stop_a: assert property (int_osc_stop_o == (ext_rst && oscillator_select_o >= CWD_OSC_INT_IO))
		else $error("oscillator stop mismatch");
	clock_output_pin_gate_a: assert property (!clock_output_oe_o |-> !clock_output_pin_o)
		else $error("clock output while not enabled");
	clock_output_pin_mode_a: assert property (clock_output_oe_o == (oscillator_select_o inside {CWD_OSC_INT_CLOCK_OUTPUT_PIN, CWD_OSC_RC_CLOCK_OUTPUT_PIN}))
		else $error("clock output enable mismatch");
	crystal_mode_a: assert property (crystal_mode_o == (oscillator_select_o <= CWD_OSC_HIGH_SPEED_XTAL))
		else $error("crystal mode mismatch");
	ext_reset_a: assert property (ext_rst |-> core_reset_o)
		else $error("external reset not held");
	wdog_off_a: assert property (!watchdog_enable_o |-> !wdog_tick_o)
		else $error("watchdog tick while disabled");
	options_hold_a: assert property (!core_reset_o ##1 !core_reset_o |-> $stable(oscillator_select_o) && $stable(bandgap_trim_o) && $stable(watchdog_enable_o))
		else $error("options changed while running");
endmodule

bind cwd_option_decoder cwd_chk cwd_chk_i (.*);

// *** tb_cwd_option_decoder.sv ***
`timescale 1ns/1ps
module tb_cwd_option_decoder;
	import cwd_pkg::*;
	localparam int BO_CYC = 20;
	logic ref_clk_i, reset_i, prog_mode_i, prog_write_i, power_on_i, brownout_i;
	logic shared_pin_three_i, wdog_osc_i, sleep_i, irq_wake_i, sys_osc_i;
	logic [13:0] prog_addr_i, prog_wdata_i, prog_rdata_o, w, prev;
	logic [1:0] bandgap_trim_o;
	logic data_protect_o, prog_protect_o, brownout_detect_enable_o, reset_pin_select_o;
	logic powerup_delay_enable_o, watchdog_enable_o, crystal_mode_o, ext_clock_accept_o;
	logic pin_one_io_o, pin_two_io_o, clock_output_pin_o, clock_output_oe_o, int_osc_stop_o;
	logic data_erase_o, prog_erase_o, core_reset_o, wdog_tick_o, wake_o;
	cwd_osc_e oscillator_select_o;
	logic [15:0] opt;
	int err_total, check_count, cycles, n, edges, ticks;

	assign opt = {bandgap_trim_o, data_protect_o, prog_protect_o, brownout_detect_enable_o,
		reset_pin_select_o, powerup_delay_enable_o, watchdog_enable_o, oscillator_select_o,
		crystal_mode_o, ext_clock_accept_o, pin_one_io_o, pin_two_io_o, clock_output_oe_o};

	cwd_option_decoder #(.POWERUP_CYC(BO_CYC), .BROWNOUT_CYC(BO_CYC), .SETTLE_CYC(16),
		.WDOG_DIV(4)) cwd_option_decoder_i (.*);
	cwd_partner cwd_partner_i (.ref_clk_i(ref_clk_i), .prog_mode_o(prog_mode_i),
		.prog_addr_o(prog_addr_i), .prog_write_o(prog_write_i), .prog_wdata_o(prog_wdata_i),
		.sys_osc_o(sys_osc_i), .wdog_osc_o(wdog_osc_i));

	// ----------------------------------------
	// Expectations and helpers
	// ----------------------------------------
	function automatic logic [15:0] expect_opt(input logic [13:0] v);
		logic [2:0] o;
		o = v[2:0];
		return {v[13:12], ~v[8], ~v[7], v[6], v[5], ~v[4], v[3], o, o <= 3'h2, o <= 3'h3,
			o[2:1] == 2'b10, o == 3'h3 || o == 3'h4 || o == 3'h6, o[2] && o[0]};
	endfunction

	task automatic check(input logic ok, input string what);
		check_count++;
		if (ok !== 1'b1)
		begin
			err_total++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic wait_run(output int k);
		k = 0;
		while (core_reset_o !== 1'b0 && k < 200)
		begin
			@(posedge ref_clk_i);
			#2;
			k++;
		end
	endtask

	// Options other than the protect bits only reload through a reset, so the external pin is pulsed.
	task automatic reload(output int k);
		@(posedge ref_clk_i);
		#2;
		shared_pin_three_i = 1'b0;
		repeat (3) @(posedge ref_clk_i);
		#2;
		shared_pin_three_i = 1'b1;
		wait_run(k);
	endtask

	// Counts divided clock rising edges and watchdog ticks over 200 cycles.
	task automatic count_edges(output int c, output int t);
		logic p;
		c = 0;
		t = 0;
		p = clock_output_pin_o;
		repeat (200)
		begin
			@(posedge ref_clk_i);
			#2;
			c += (clock_output_pin_o === 1'b1 && p === 1'b0);
			t += (wdog_tick_o === 1'b1);
			p = clock_output_pin_o;
		end
	endtask

	initial
	begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	always @(posedge ref_clk_i)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			err_total++;
			conclude();
		end
	end

	initial
	begin
		reset_i = 1'b1;
		power_on_i = 1'b0;
		brownout_i = 1'b0;
		shared_pin_three_i = 1'b1;
		sleep_i = 1'b0;
		irq_wake_i = 1'b0;
		prev = 14'h3fff;
		void'($urandom(32'hb4cb4665));
		repeat (10) @(posedge ref_clk_i);
		#2;
		reset_i = 1'b0;
		cwd_partner_i.put(14'h2006, 14'h0000, 1'b1);
		check(prog_rdata_o === 14'h0000, "refused address");
		for (int i = 0; i < 12; i++)
		begin
			w = 14'($urandom()) | 14'h0020;
			if (i < 8)
				w[2:0] = 3'(i);
			if (i == 1)
				w[8:7] = 2'b00;
			if (i == 2)
				w[8:7] = 2'b11;
			cwd_partner_i.put(14'h2007, w, 1'b1);
			check(data_erase_o === (!prev[8] && w[8]) && prog_erase_o === (!prev[7] && w[7]), "erase");
			prev = w;
			repeat (2) @(posedge ref_clk_i);
			#2;
			check(prog_rdata_o === (w & 14'h31ff), "readback");
			cwd_partner_i.put(14'h2007, ~w, 1'b0);
			check(data_erase_o === 1'b0 && prog_erase_o === 1'b0, "refused erase");
			check(prog_rdata_o === 14'h0000, "hidden outside programming");
			reload(n);
			check(opt === expect_opt(w) && n < 200, "decode");
			count_edges(edges, ticks);
			check((w[2] && w[0]) ? (edges >= 19 && edges <= 21) : edges == 0, "clock_output_pin rate");
			check(w[3] ? (ticks >= 15 && ticks <= 17) : ticks == 0, "watchdog rate");
			$display("test %0d word %h done", i, w);
		end
		power_on_i = 1'b1;
		for (int j = 0; j < 2; j++)
		begin
			cwd_partner_i.put(14'h2007, j == 1 ? 14'h3164 : 14'h3174, 1'b1);
			reload(n);
			check((n >= BO_CYC) === (j == 1) && n < 200, "power-up delay");
		end
		power_on_i = 1'b0;
		brownout_i = 1'b1;
		repeat (3) @(posedge ref_clk_i);
		#2;
		brownout_i = 1'b0;
		wait_run(n);
		check(n >= BO_CYC && n < 200, "brown-out hold");
		$display("test delays done");
		@(posedge ref_clk_i);
		#2;
		sleep_i = 1'b1;
		#1;
		check(wake_o === 1'b0, "no wake cause");
		@(posedge ref_clk_i);
		#2;
		irq_wake_i = 1'b1;
		#1;
		check(wake_o === 1'b1, "irq wake");
		@(posedge ref_clk_i);
		#2;
		irq_wake_i = 1'b0;
		shared_pin_three_i = 1'b0;
		#1;
		check(wake_o === 1'b1 && int_osc_stop_o === 1'b1, "reset wake");
		@(posedge ref_clk_i);
		#2;
		shared_pin_three_i = 1'b1;
		sleep_i = 1'b0;
		$display("test wake done");
		conclude();
	end
endmodule
